/* File: flash_pkg.sv */
package flash_pkg;
    // special function register addresses
    localparam logic [7:0] PROGRAM_STORE_CONTROL_ADDR     = 8'h8f;
    localparam logic [7:0] FLASH_SCALE_CONTROL_ADDR     = 8'hb6;
    localparam logic [7:0] FLASH_UNLOCK_KEY_ADDR     = 8'hb7;
    // reset values
    localparam logic [7:0] PROGRAM_STORE_CONTROL_RESET    = 8'h00;
    localparam logic [7:0] FLASH_SCALE_CONTROL_RESET    = 8'h80;
    // field positions
    localparam int         WE_BIT         = 0;
    localparam int         EE_BIT         = 1;
    localparam int         ONE_SHOT_BIT   = 7;
    // key codes
    localparam logic [7:0] KEY_FIRST      = 8'ha5;
    localparam logic [7:0] KEY_SECOND     = 8'hf1;
    // memory layout
    localparam int         ADDR_W         = 14;
    localparam int         PAGE_W         = 5;
    localparam logic [4:0] RESERVED_PAGE  = 5'h1f;
    localparam logic [4:0] LOCK_BYTE_PAGE = 5'h1e;
    localparam logic [13:0] LOCK_BYTE_ADDR = 14'h3dff;
    localparam logic [7:0] ERASED_BYTE    = 8'hff;
    // operation times at 100 ns per clock
    localparam int         CLK_NS         = 100;
    localparam int         WRITE_US       = 40;
    localparam int         ERASE_MS       = 10;
    localparam int         WRITE_CYCLES   = (WRITE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int         ERASE_CYCLES   = (ERASE_MS * 1000000 + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        KEY_LOCKED   = 2'b00,
        KEY_FIRST_OK = 2'b01,
        KEY_OPEN     = 2'b10,
        KEY_DEAD     = 2'b11
    } key_state_t;

    typedef enum logic [1:0] {
        OP_IDLE  = 2'b00,
        OP_WRITE = 2'b01,
        OP_ERASE = 2'b11,
        OP_DONE  = 2'b10
    } op_state_t;
endpackage

/* File: page_guard_if.sv */
`timescale 1ns/1ns
interface page_guard_if;
    import flash_pkg::*;
    logic [7:0]        lock_byte;
    logic [PAGE_W-1:0] exec_page;
    logic [PAGE_W-1:0] target_page;
    logic              is_erase;
    logic              from_debug;
    logic              allow;

    modport checker_side (
        input  lock_byte, exec_page, target_page, is_erase, from_debug,
        output allow
    );
    modport user_side (
        output lock_byte, exec_page, target_page, is_erase, from_debug,
        input  allow
    );
endinterface

/* File: page_guard.sv */
`timescale 1ns/1ns
module page_guard
    import flash_pkg::*;
(
    page_guard_if.checker_side g
);
    logic [7:0] locked_count;
    logic       any_locked;
    logic       exec_locked;
    logic       target_locked;
    logic       target_reserved;

    always_comb begin
        locked_count    = ~g.lock_byte;                                  // R17
        any_locked      = (locked_count != 8'h00);
        // lock byte page joins the locked set when anything is locked
        exec_locked     = ({3'b000, g.exec_page} < locked_count)
                          || (any_locked && g.exec_page == LOCK_BYTE_PAGE);   // R01 R21
        target_locked   = ({3'b000, g.target_page} < locked_count)
                          || (any_locked && g.target_page == LOCK_BYTE_PAGE); // R01
        target_reserved = (g.target_page == RESERVED_PAGE);              // R19
        if (g.from_debug) begin
            g.allow = !target_locked;                                    // R02
        end else if (target_reserved) begin
            g.allow = 1'b0;                                              // R04 R19
        end else if (!exec_locked) begin
            g.allow = !target_locked;                                    // R03
        end else begin
            g.allow = !(g.is_erase && any_locked
                        && g.target_page == LOCK_BYTE_PAGE);             // R05
        end
    end
endmodule

/* File: flash_write_erase_protection.sv */
// Functional notes
// R01: any lock bit cleared locks lock-byte page
// R02: debug port refused on locked pages
// R03: unlocked code refused on locked pages
// R04: locked code reads/writes all but reserved
// R05: locked code erases all but reserved, lock page
// R06: only debug device erase unlocks pages
// R07: denied firmware access resets, cause recorded; a denied read is ignored in a cycle with a flash movx write
// R08: erase and write enable erase whole page
// R09: write enable steers writes to program memory
// R10: control bits 7-2 read zero
// R11: key 0xa5 then 0xf1 unlocks
// R12: unlock lasts one operation only
// R13: bad key or early op disables until reset
// R14: key register reads lock state bits 1-0
// R15: scale bit 7 selects read one-shot
// R16: scale bits 6-0 read zero
// R17: locked page count is complement of lock byte
// R18: write only clears bits; erase sets 0xff
// R19: top 512 bytes reserved from firmware
// R20: operations self-timed, core stalled meanwhile
// R21: execute page compared with locked range
`timescale 1ns/1ns
module flash_write_erase_protection
    import flash_pkg::*;
#(
    parameter int ERASE_CNT = ERASE_CYCLES,
    parameter int WRITE_CNT = WRITE_CYCLES
) (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    // special function register port
    input  wire logic              i_sfr_wr,
    input  wire logic              i_sfr_rd,
    input  wire logic [7:0]        i_sfr_addr,
    input  wire logic [7:0]        i_sfr_wdata,
    output logic      [7:0]        o_sfr_rdata,
    // external-move write from the core
    input  wire logic              i_movx_wr,
    input  wire logic [15:0]       i_movx_addr,
    input  wire logic [7:0]        i_movx_wdata,
    input  wire logic [ADDR_W-1:0] i_pc,
    output logic                   o_xram_wr,
    output logic                   o_stall,
    // firmware code read check
    input  wire logic              i_code_rd,
    input  wire logic [ADDR_W-1:0] i_code_addr,
    output logic                   o_code_rd_ok,
    // two-wire debug port requests
    input  wire logic              i_dbg_req,
    input  wire logic              i_dbg_erase,
    input  wire logic              i_dbg_dev_erase,
    input  wire logic [ADDR_W-1:0] i_dbg_addr,
    output logic                   o_dbg_allow,
    // flash array
    input  wire logic [7:0]        i_lock_byte,
    input  wire logic [7:0]        i_flash_rdata,
    output logic                   o_flash_wr,
    output logic                   o_flash_page_erase,
    output logic                   o_flash_dev_erase,
    output logic [ADDR_W-1:0]      o_flash_addr,
    output logic [7:0]             o_flash_wdata,
    output logic                   o_read_one_shot,
    // reset request
    output logic                   o_sys_reset_req,
    output logic                   o_flash_error
);
    ////////////////////////////////////////////////////////////////////////////////
    localparam int CNT_W = $clog2(ERASE_CNT + 1);

    logic [1:0]        program_store_control_r, program_store_control_nxt;
    logic              one_shot_r, one_shot_nxt;
    key_state_t        key_r, key_nxt;
    op_state_t         op_r, op_nxt;
    logic [CNT_W-1:0]  cnt_r, cnt_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [7:0]        data_r, data_nxt;
    logic              err_r, err_nxt;
    logic              rst_req_r, rst_req_nxt;
    logic              dev_erase_r, dev_erase_nxt;
    logic [7:0]        rdata_r, rdata_nxt;

    page_guard_if fw_g ();
    page_guard_if rd_g ();
    page_guard_if dbg_g ();

    ////////////////////////////////////////////////////////////////////////////////
    // page checks for firmware write, firmware read and debug port
    assign fw_g.lock_byte    = i_lock_byte;
    assign fw_g.exec_page    = i_pc[ADDR_W-1 -: PAGE_W];
    assign fw_g.target_page  = i_movx_addr[ADDR_W-1 -: PAGE_W];
    assign fw_g.is_erase     = program_store_control_r[EE_BIT];
    assign fw_g.from_debug   = 1'b0;
    assign rd_g.lock_byte    = i_lock_byte;
    assign rd_g.exec_page    = i_pc[ADDR_W-1 -: PAGE_W];
    assign rd_g.target_page  = i_code_addr[ADDR_W-1 -: PAGE_W];
    assign rd_g.is_erase     = 1'b0;
    assign rd_g.from_debug   = 1'b0;
    assign dbg_g.lock_byte   = i_lock_byte;
    assign dbg_g.exec_page   = '0;
    assign dbg_g.target_page = i_dbg_addr[ADDR_W-1 -: PAGE_W];
    assign dbg_g.is_erase    = i_dbg_erase;
    assign dbg_g.from_debug  = 1'b1;

    page_guard u_fw_guard  (.g(fw_g.checker_side));
    page_guard u_rd_guard  (.g(rd_g.checker_side));
    page_guard u_dbg_guard (.g(dbg_g.checker_side));

    // reads of code space are not a write; reserved page is refused to firmware reads from any page
    logic rd_ok;
    always_comb begin
        if (rd_g.exec_page == RESERVED_PAGE || rd_g.target_page != RESERVED_PAGE) begin
            rd_ok = rd_g.allow;
        end else begin
            rd_ok = 1'b0;
        end
    end

    assign o_dbg_allow  = i_dbg_dev_erase || (i_dbg_req && dbg_g.allow);   // R02 R06
    assign o_code_rd_ok = i_code_rd && rd_ok;                              // R03 R04

    ////////////////////////////////////////////////////////////////////////////////
    // registers, key sequencing and operation timing
    logic movx_fl;
    logic read_denied;
    assign movx_fl     = i_movx_wr && program_store_control_r[WE_BIT] && op_r == OP_IDLE;  // R09
    assign read_denied = i_code_rd && !rd_ok;

    always_comb begin
        program_store_control_nxt     = program_store_control_r;
        one_shot_nxt  = one_shot_r;
        key_nxt       = key_r;
        op_nxt        = op_r;
        cnt_nxt       = cnt_r;
        addr_nxt      = addr_r;
        data_nxt      = data_r;
        err_nxt       = err_r;
        rst_req_nxt   = 1'b0;
        dev_erase_nxt = 1'b0;
        rdata_nxt     = rdata_r;

        if (i_sfr_wr) begin
            case (i_sfr_addr)
                PROGRAM_STORE_CONTROL_ADDR: program_store_control_nxt  = i_sfr_wdata[1:0];                 // R10
                FLASH_SCALE_CONTROL_ADDR: one_shot_nxt = i_sfr_wdata[ONE_SHOT_BIT];      // R15 R16
                FLASH_UNLOCK_KEY_ADDR: begin
                    case (key_r)
                        KEY_LOCKED:   key_nxt = (i_sfr_wdata == KEY_FIRST)
                                                ? KEY_FIRST_OK : KEY_DEAD;   // R11 R13
                        KEY_FIRST_OK: key_nxt = (i_sfr_wdata == KEY_SECOND)
                                                ? KEY_OPEN : KEY_DEAD;       // R11 R13
                        KEY_OPEN:     key_nxt = KEY_DEAD;                    // R13
                        default:      key_nxt = KEY_DEAD;
                    endcase
                end
                default: ;
            endcase
        end

        if (i_sfr_rd) begin
            case (i_sfr_addr)
                PROGRAM_STORE_CONTROL_ADDR: rdata_nxt = {6'h00, program_store_control_r};                  // R10
                FLASH_SCALE_CONTROL_ADDR: rdata_nxt = {one_shot_r, 7'h00};               // R16
                FLASH_UNLOCK_KEY_ADDR: rdata_nxt = {6'h00, key_r};                    // R14
                default:    rdata_nxt = 8'h00;
            endcase
        end

        if (movx_fl) begin
            if (!fw_g.allow) begin
                rst_req_nxt = 1'b1;                                        // R07
                err_nxt     = 1'b1;                                        // R07
                key_nxt     = KEY_LOCKED;
            end else if (key_r != KEY_OPEN) begin
                key_nxt = KEY_DEAD;                                        // R13
            end else begin
                key_nxt  = KEY_LOCKED;                                     // R12
                addr_nxt = i_movx_addr[ADDR_W-1:0];
                if (program_store_control_r[EE_BIT]) begin
                    op_nxt   = OP_ERASE;                                   // R08
                    cnt_nxt  = CNT_W'(ERASE_CNT - 1);
                    data_nxt = ERASED_BYTE;                                // R18
                end else begin
                    op_nxt   = OP_WRITE;
                    cnt_nxt  = CNT_W'(WRITE_CNT - 1);
                    data_nxt = i_movx_wdata & i_flash_rdata;               // R18
                end
            end
        end else if (read_denied && !rst_req_r) begin
            rst_req_nxt = 1'b1;                                            // R07
            err_nxt     = 1'b1;
        end

        case (op_r)
            OP_IDLE: ;
            OP_WRITE, OP_ERASE: begin
                if (cnt_r == '0) begin
                    op_nxt = OP_DONE;                                      // R20
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            OP_DONE: op_nxt = OP_IDLE;
            default: op_nxt = OP_IDLE;
        endcase

        if (i_dbg_dev_erase) begin
            dev_erase_nxt = 1'b1;                                          // R06
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            program_store_control_r     <= PROGRAM_STORE_CONTROL_RESET[1:0];
            one_shot_r  <= FLASH_SCALE_CONTROL_RESET[ONE_SHOT_BIT];
            key_r       <= KEY_LOCKED;
            op_r        <= OP_IDLE;
            cnt_r       <= '0;
            addr_r      <= '0;
            data_r      <= 8'h00;
            err_r       <= 1'b0;
            rst_req_r   <= 1'b0;
            dev_erase_r <= 1'b0;
            rdata_r     <= 8'h00;
        end else begin
            program_store_control_r     <= program_store_control_nxt;
            one_shot_r  <= one_shot_nxt;
            key_r       <= key_nxt;
            op_r        <= op_nxt;
            cnt_r       <= cnt_nxt;
            addr_r      <= addr_nxt;
            data_r      <= data_nxt;
            err_r       <= err_nxt;
            rst_req_r   <= rst_req_nxt;
            dev_erase_r <= dev_erase_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_sfr_rdata        = rdata_r;
    assign o_xram_wr          = i_movx_wr && !program_store_control_r[WE_BIT];             // R09
    assign o_stall            = (op_r == OP_WRITE) || (op_r == OP_ERASE)
                                || movx_fl;                                // R20
    assign o_flash_wr         = (op_r == OP_WRITE);
    assign o_flash_page_erase = (op_r == OP_ERASE);                        // R08
    assign o_flash_dev_erase  = dev_erase_r;                               // R06
    assign o_flash_addr       = addr_r;
    assign o_flash_wdata      = data_r;
    assign o_read_one_shot    = one_shot_r;                                // R15
    assign o_sys_reset_req    = rst_req_r;                                 // R07
    assign o_flash_error      = err_r;
endmodule

/* File: flash_array_model.sv */
`timescale 1ns/1ns
module flash_array_model
    import flash_pkg::*;
#(
    parameter logic [7:0] INIT_LOCK = 8'hfd
) (
    input  wire logic              i_clk,
    input  wire logic              i_wr,
    input  wire logic              i_page_erase,
    input  wire logic              i_dev_erase,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic [ADDR_W-1:0] i_rd_addr,
    output logic      [7:0]        o_rdata,
    output logic      [7:0]        o_lock_byte
);
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    initial begin
        foreach (mem[i]) mem[i] = ERASED_BYTE;
        mem[LOCK_BYTE_ADDR] = INIT_LOCK;
    end
    assign o_rdata     = mem[i_rd_addr];
    assign o_lock_byte = mem[LOCK_BYTE_ADDR];
    always @(posedge i_clk) begin
        if (i_dev_erase) begin
            foreach (mem[i]) mem[i] <= ERASED_BYTE;
        end else if (i_page_erase) begin
            for (int i = 0; i < 512; i++) mem[{i_addr[ADDR_W-1:9], 9'(i)}] <= ERASED_BYTE;
        end else if (i_wr) begin
            mem[i_addr] <= mem[i_addr] & i_wdata;
        end
    end
endmodule

/* File: flash_wep_checker.sv */
`timescale 1ns/1ns
module flash_wep_checker
    import flash_pkg::*;
#(
    parameter int ERASE_CNT = 20,
    parameter int WRITE_CNT = 5
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_movx_wr,
    input wire logic i_dbg_req,
    input wire logic i_dbg_dev_erase,
    input wire logic o_xram_wr,
    input wire logic o_stall,
    input wire logic o_dbg_allow,
    input wire logic o_flash_wr,
    input wire logic o_flash_page_erase,
    input wire logic o_flash_dev_erase,
    input wire logic o_read_one_shot,
    input wire logic o_sys_reset_req,
    input wire logic o_flash_error
);
    int op_cnt_r;
    int op_cnt_nxt;
    always_comb begin
        op_cnt_nxt = (o_flash_wr || o_flash_page_erase) ? op_cnt_r + 1 : 0;
    end
    always_ff @(posedge i_clk) begin
        op_cnt_r <= i_reset ? 0 : op_cnt_nxt;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_xram_steer: assert property (o_xram_wr |-> i_movx_wr)
        else $error("xram write without core write");
    a_write_time: assert property ($fell(o_flash_wr) |-> op_cnt_r == WRITE_CNT)
        else $error("write window length wrong");
    a_erase_time: assert property ($fell(o_flash_page_erase) |-> op_cnt_r == ERASE_CNT)
        else $error("erase window length wrong");
    a_busy_stall: assert property (o_flash_wr || o_flash_page_erase |-> o_stall)
        else $error("core not stalled during operation");
    a_reset_pulse: assert property (o_sys_reset_req |=> !o_sys_reset_req)
        else $error("reset request longer than one cycle");
    a_error_cause: assert property (o_sys_reset_req |=> o_flash_error)
        else $error("reset request without error cause");
    a_error_sticky: assert property (o_flash_error |=> o_flash_error)
        else $error("error cause dropped");
    a_dev_erase: assert property ($rose(i_dbg_dev_erase) |=> o_flash_dev_erase)
        else $error("device erase not issued");
    a_dev_allow: assert property (i_dbg_req && i_dbg_dev_erase |-> o_dbg_allow)
        else $error("device erase refused");
    a_one_shot_rst: assert property ($fell(i_reset) |-> o_read_one_shot)
        else $error("one-shot not enabled after reset");
    c_write: cover property ($rose(o_flash_wr));
    c_erase: cover property ($rose(o_flash_page_erase));
    c_deny: cover property (o_sys_reset_req);
endmodule
bind flash_write_erase_protection flash_wep_checker #(
    .ERASE_CNT(ERASE_CNT),
    .WRITE_CNT(WRITE_CNT)
) chk_i (.*);

/* File: test_flash_write_erase_protection.sv */
`timescale 1ns/1ns
module test_flash_write_erase_protection;
    import flash_pkg::*;
    logic              i_clk = 1'b0, i_reset = 1'b1, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0;
    logic              i_movx_wr = 1'b0, i_code_rd = 1'b0, i_dbg_req = 1'b0;
    logic              i_dbg_erase = 1'b0, i_dbg_dev_erase = 1'b0;
    logic [7:0]        i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, i_movx_wdata = 8'h00;
    logic [7:0]        i_lock_byte, i_flash_rdata, o_sfr_rdata, o_flash_wdata;
    logic [15:0]       i_movx_addr = 16'h0000;
    logic [ADDR_W-1:0] i_pc = 14'h0000, i_code_addr = 14'h0000, i_dbg_addr = 14'h0000;
    logic [ADDR_W-1:0] o_flash_addr;
    logic              o_xram_wr, o_stall, o_code_rd_ok, o_dbg_allow, o_flash_wr;
    logic              o_flash_page_erase, o_flash_dev_erase, o_read_one_shot;
    logic              o_sys_reset_req, o_flash_error;
    int                n_fail = 0, total_checks = 0, cycles = 0;
    always #50 i_clk = ~i_clk;
    flash_write_erase_protection #(.ERASE_CNT(20), .WRITE_CNT(5)) dut (.*);
    flash_array_model fm (.i_clk(i_clk), .i_wr(o_flash_wr), .i_page_erase(o_flash_page_erase),
        .i_dev_erase(o_flash_dev_erase), .i_addr(o_flash_addr), .i_wdata(o_flash_wdata),
        .i_rd_addr(i_movx_addr[ADDR_W-1:0]), .o_rdata(i_flash_rdata), .o_lock_byte(i_lock_byte));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_sfr_wr <= 1'b1;
        i_sfr_addr <= a;
        i_sfr_wdata <= d;
        @(posedge i_clk);
        i_sfr_wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_sfr_rd <= 1'b1;
        i_sfr_addr <= a;
        @(posedge i_clk);
        i_sfr_rd <= 1'b0;
        @(negedge i_clk);
        chk(o_sfr_rdata, e);
    endtask
    task automatic key();
        sfr_w(FLASH_UNLOCK_KEY_ADDR, KEY_FIRST);
        sfr_w(FLASH_UNLOCK_KEY_ADDR, KEY_SECOND);
    endtask
    task automatic movx(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_movx_wr <= 1'b1;
        i_movx_addr <= a;
        i_movx_wdata <= d;
        @(posedge i_clk);
        i_movx_wr <= 1'b0;
        @(negedge i_clk);
        repeat (100) begin
            if (o_stall !== 1'b1) break;
            @(negedge i_clk);
        end
    endtask
    task automatic rst();
        @(posedge i_clk);
        i_reset <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        @(negedge i_clk);
    endtask
    task automatic probe(input logic [13:0] pc, input logic [13:0] a, input logic e);
        @(posedge i_clk);
        i_pc <= pc;
        i_code_addr <= a;
        i_dbg_addr <= a;
        @(negedge i_clk);
        chk(i_dbg_req ? o_dbg_allow : o_code_rd_ok, e);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rchk(PROGRAM_STORE_CONTROL_ADDR, PROGRAM_STORE_CONTROL_RESET);
        rchk(FLASH_SCALE_CONTROL_ADDR, FLASH_SCALE_CONTROL_RESET);
        rchk(FLASH_UNLOCK_KEY_ADDR, 8'h00);
        sfr_w(PROGRAM_STORE_CONTROL_ADDR, 8'hf8);
        rchk(PROGRAM_STORE_CONTROL_ADDR, 8'h00);
        sfr_w(FLASH_SCALE_CONTROL_ADDR, 8'h00);
        rchk(FLASH_SCALE_CONTROL_ADDR, 8'h00);
        chk(o_read_one_shot, 1'b0);
        sfr_w(FLASH_SCALE_CONTROL_ADDR, 8'h80);
        rchk(FLASH_SCALE_CONTROL_ADDR, 8'h80);
        $display("regs test done");
    endtask
    task automatic t_write_erase();
        i_pc <= 14'h0a00;
        sfr_w(FLASH_UNLOCK_KEY_ADDR, KEY_FIRST);
        rchk(FLASH_UNLOCK_KEY_ADDR, 8'h01);
        sfr_w(FLASH_UNLOCK_KEY_ADDR, KEY_SECOND);
        rchk(FLASH_UNLOCK_KEY_ADDR, 8'h02);
        sfr_w(PROGRAM_STORE_CONTROL_ADDR, 8'h01);
        movx(16'h0a10, 8'h3c);
        chk(fm.mem[14'h0a10], 8'h3c);
        rchk(FLASH_UNLOCK_KEY_ADDR, 8'h00);
        key();
        movx(16'h0a10, 8'hc3);
        chk(fm.mem[14'h0a10], 8'h00);
        key();
        sfr_w(PROGRAM_STORE_CONTROL_ADDR, 8'h03);
        movx(16'h0a55, 8'h00);
        chk(fm.mem[14'h0a10], ERASED_BYTE);
        sfr_w(PROGRAM_STORE_CONTROL_ADDR, 8'h00);
        @(posedge i_clk);
        i_movx_wr <= 1'b1;
        @(negedge i_clk);
        chk(o_xram_wr, 1'b1);
        @(posedge i_clk);
        i_movx_wr <= 1'b0;
        $display("write erase test done");
    endtask
    task automatic t_access();
        i_code_rd <= 1'b1;
        probe(14'h0a00, 14'h0000, 1'b0);
        probe(14'h0a00, 14'h3c00, 1'b0);
        probe(14'h0a00, 14'h0400, 1'b1);
        probe(14'h0000, 14'h0200, 1'b1);
        probe(14'h0000, 14'h3e00, 1'b0);
        i_code_rd <= 1'b0;
        i_dbg_req <= 1'b1;
        probe(14'h0000, 14'h0200, 1'b0);
        i_dbg_erase <= 1'b1;
        probe(14'h0000, 14'h0400, 1'b1);
        i_dbg_req <= 1'b0;
        i_dbg_erase <= 1'b0;
        $display("access test done");
    endtask
    task automatic t_faults();
        i_pc <= 14'h0000;
        key();
        sfr_w(PROGRAM_STORE_CONTROL_ADDR, 8'h03);
        movx(16'h3c00, 8'h00);
        chk(o_sys_reset_req, 1'b1);
        chk(fm.mem[LOCK_BYTE_ADDR], 8'hfd);
        @(negedge i_clk);
        chk(o_flash_error, 1'b1);
        rst();
        chk(o_flash_error, 1'b0);
        i_pc <= 14'h0a00;
        sfr_w(FLASH_UNLOCK_KEY_ADDR, 8'h11);
        rchk(FLASH_UNLOCK_KEY_ADDR, 8'h03);
        key();
        sfr_w(PROGRAM_STORE_CONTROL_ADDR, 8'h01);
        movx(16'h0b00, 8'h00);
        chk(fm.mem[14'h0b00], ERASED_BYTE);
        rst();
        $display("fault test done");
    endtask
    task automatic t_dev_erase();
        @(posedge i_clk);
        i_dbg_req <= 1'b1;
        i_dbg_dev_erase <= 1'b1;
        @(posedge i_clk);
        i_dbg_dev_erase <= 1'b0;
        repeat (3) @(negedge i_clk);
        chk(fm.mem[LOCK_BYTE_ADDR], ERASED_BYTE);
        probe(14'h0a00, 14'h0000, 1'b1);
        i_dbg_req <= 1'b0;
        $display("device erase test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        t_regs();
        t_write_erase();
        t_access();
        t_faults();
        t_dev_erase();
        results();
    end
endmodule
